// [hw/srtw_pkg.sv]
// srtw_pkg: constants for the sdram refresh timer and reset wait block
// assumes: AXI4-Lite with 32-bit data, one aligned word per register
package srtw_pkg;
  // --------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_CSR = 8'h00;
  localparam logic [7:0] ADDR_CNT = 8'h04;
  localparam logic [7:0] ADDR_COR = 8'h08;
  localparam logic [7:0] ADDR_SDRAM_CONTROL_REGISTER = 8'h0C;
  localparam int ADDR_W = 8;
  // --------------------------------------------------------------------
  // fields
  // --------------------------------------------------------------------
  localparam logic [15:0] WRITE_KEY = 16'hA55A;
  localparam int KEY_LSB = 16;
  localparam int CMF_BIT = 7;
  localparam int COMPARE_INTERRUPT_ENABLE_BIT = 6;
  localparam int CKS_LSB = 3;
  localparam int RRC_LSB = 0;
  localparam int REFRESH_ENABLE_BIT = 0;
  localparam logic [3:0] FULL_STROBE = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // --------------------------------------------------------------------
  // prescaler and wait counter
  // --------------------------------------------------------------------
  localparam int PRESC_W = 12;
  localparam logic [6:0] WAIT_TERMINAL = 7'h7F;
  typedef logic [2:0] srtw_sel_t;
  typedef enum logic [1:0] {SRTW_IDLE, SRTW_WRESP, SRTW_RRESP}
    srtw_bus_e;
endpackage

// [hw/srtw_prescaler.sv]
// srtw_prescaler: free running bus clock divider with selectable tap
// assumes: one clock domain, tick is a one-cycle pulse
`timescale 1ns/1ps
module srtw_prescaler #(
  parameter int WIDTH = srtw_pkg::PRESC_W
) (
  input wire logic clock, // bus clock
  input wire logic arst_n, // async reset, active low
  input wire srtw_pkg::srtw_sel_t sel, // prescale select
  output logic tick // one-cycle count enable
);
  import srtw_pkg::*;
  initial begin
    if (WIDTH < 12) $error("prescaler too narrow for divide by 4096");
  end
  typedef struct packed {
    logic [WIDTH-1:0] div;
  } srtw_presc_s;
  srtw_presc_s st, next_st;
  logic [WIDTH-1:0] mask;
  always_comb begin
    next_st = st;
    next_st.div = st.div + 1'b1;
    unique case (sel)
      3'h1: mask = WIDTH'(12'h003);
      3'h2: mask = WIDTH'(12'h00F);
      3'h3: mask = WIDTH'(12'h03F);
      3'h4: mask = WIDTH'(12'h0FF);
      3'h5: mask = WIDTH'(12'h3FF);
      3'h6: mask = WIDTH'(12'h7FF);
      3'h7: mask = WIDTH'(12'hFFF);
      default: mask = '0;
    endcase
  end
  // stop setting never ticks
  assign tick = (sel != 3'h0) && ((st.div & mask) == mask);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// [hw/srtw_refresh_timer.sv]
// srtw_refresh_timer: sdram refresh interval timer and post reset wait
// assumes: AXI4-Lite master on the bus clock, sequencer acks refreshes
//
// Behaviour
// - 8-bit counter advances on bus clock divided 4 to 4096 per select.
// - select 000 halts counter, 001 divides bus clock by 4.
// - repeat field 000..100 gives 1,2,4,6,8 refresh cycles per request.
// - only full 32-bit writes reach the three protected registers.
// - protected register write takes effect only when upper 16 data bits equal the key.
// - protected registers read zero in their upper 16 bits.
// - counter clears to zero on compare match.
// - without match counter wraps from 255 to zero.
// - compare match sets the compare match flag.
// - with refresh enabled every match raises a refresh request.
// - pending refresh request holds until the sequencer performs it.
// - a match during a pending request never queues a second one.
// - with interrupt enabled match raises irq until flag cleared.
// - clearing the flag drops only the irq, not refresh request.
// - flag clears only on writing 0 after reading it as 1.
// - compare constant bits above 7 read zero.
// - 7-bit wait counter starts counting after reset release.
// - wait counter stops for good at 127.
// - external bus access stalls while wait counter counts.
// - wait counter has no software access.
`timescale 1ns/1ps
module srtw_refresh_timer
  import srtw_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int WAIT_W = 7
) (
  input wire logic clock, // bus clock, 20 MHz
  input wire logic arst_n, // power-on reset, active low
  input wire logic [srtw_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [srtw_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic refreshReq, // refresh request to sequencer
  output logic [3:0] refreshCycles, // consecutive refresh cycles
  input wire logic refreshAck, // sequencer finished the refresh
  output logic compareIrq, // compare match interrupt, level
  output logic extBusStall // external bus access must wait
);
  initial begin
    if (CNT_W != 8) $error("refresh counter must be 8 bits");
    if (WAIT_W != 7) $error("wait counter must be 7 bits");
  end

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    srtw_bus_e bus;
    logic awTaken;
    logic wTaken;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] bResp;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic compareMatchFlag;
    logic flagSeenSet;
    logic compareInterruptEnable;
    srtw_sel_t prescaleSelect;
    logic [2:0] refreshRepeat;
    logic refreshEnable;
    logic [CNT_W-1:0] refreshIntervalCounter;
    logic [CNT_W-1:0] refreshCompareConstant;
    logic reqPending;
    logic [3:0] reqCycles;
    logic [WAIT_W-1:0] postResetWaitCounter;
  } srtw_state_s;

  srtw_state_s st, next_st;
  logic tick;
  logic match;
  logic wrFire;
  logic keyOk;
  logic fullWord;
  logic [3:0] cyclesSel;

  srtw_prescaler #(.WIDTH(PRESC_W)) u_presc (
    .clock(clock),
    .arst_n(arst_n),
    .sel(st.prescaleSelect),
    .tick(tick)
  );

  // --------------------------------------------------------------------
  // combinational next state
  // --------------------------------------------------------------------
  assign match = st.refreshIntervalCounter == st.refreshCompareConstant;
  assign fullWord = st.wStrb == FULL_STROBE;
  assign keyOk = st.wData[31:KEY_LSB] == WRITE_KEY;
  assign wrFire = st.bus == SRTW_IDLE && st.awTaken && st.wTaken;

  always_comb begin
    unique case (st.refreshRepeat)
      3'h0: cyclesSel = 4'h1;
      3'h1: cyclesSel = 4'h2;
      3'h2: cyclesSel = 4'h4;
      3'h3: cyclesSel = 4'h6;
      3'h4: cyclesSel = 4'h8;
      // prohibited codes: treat as the largest legal count
      default: cyclesSel = 4'h8;
    endcase
  end

  always_comb begin
    next_st = st;
    // bus channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awTaken = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wTaken = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    // refresh counter, only on a prescaler tick
    if (tick) begin
      if (match) begin
        next_st.refreshIntervalCounter = '0;
      end else begin
        // natural 8-bit wrap after 255
        next_st.refreshIntervalCounter =
          st.refreshIntervalCounter + 1'b1;
      end
    end
    // sequencer ack clears pending request
    if (refreshAck && st.reqPending) begin
      next_st.reqPending = 1'b0;
    end
    // post-reset wait counter, no software path reaches it
    if (st.postResetWaitCounter != WAIT_TERMINAL) begin
      next_st.postResetWaitCounter =
        st.postResetWaitCounter + 1'b1;
    end
    // register writes
    if (wrFire) begin
      next_st.awTaken = 1'b0;
      next_st.wTaken = 1'b0;
      next_st.bus = SRTW_WRESP;
      next_st.bResp = RESP_OKAY;
      unique case (st.awAddr)
        ADDR_CSR: begin
          if (fullWord && keyOk) begin
            next_st.compareInterruptEnable = st.wData[COMPARE_INTERRUPT_ENABLE_BIT];
            next_st.prescaleSelect = st.wData[CKS_LSB +: 3];
            next_st.refreshRepeat = st.wData[RRC_LSB +: 3];
            if (!st.wData[CMF_BIT] && st.flagSeenSet) begin
              next_st.compareMatchFlag = 1'b0;
              next_st.flagSeenSet = 1'b0;
            end
          end
        end
        ADDR_CNT: begin
          if (fullWord && keyOk) begin
            next_st.refreshIntervalCounter = st.wData[CNT_W-1:0];
          end
        end
        ADDR_COR: begin
          if (fullWord && keyOk) begin
            next_st.refreshCompareConstant = st.wData[CNT_W-1:0];
          end
        end
        ADDR_SDRAM_CONTROL_REGISTER: begin
          if (st.wStrb[0]) begin
            next_st.refreshEnable = st.wData[REFRESH_ENABLE_BIT];
          end
        end
        default: next_st.bResp = RESP_SLVERR;
      endcase
    end
    // compare match: hardware set wins over a software clear
    if (tick && match) begin
      next_st.compareMatchFlag = 1'b1;
      if (st.refreshEnable) begin
        // one pending request at most; older one is replaced
        next_st.reqPending = 1'b1;
        next_st.reqCycles = cyclesSel;
      end
    end
    if (st.bus == SRTW_WRESP && s_axi_bready) begin
      next_st.bus = SRTW_IDLE;
    end
    // reads
    if (st.bus == SRTW_IDLE && !wrFire && s_axi_arvalid) begin
      next_st.bus = SRTW_RRESP;
      next_st.rData = '0;
      next_st.rResp = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CSR: begin
          next_st.rData[CMF_BIT] = st.compareMatchFlag;
          next_st.rData[COMPARE_INTERRUPT_ENABLE_BIT] = st.compareInterruptEnable;
          next_st.rData[CKS_LSB +: 3] = st.prescaleSelect;
          next_st.rData[RRC_LSB +: 3] = st.refreshRepeat;
          if (st.compareMatchFlag) begin
            next_st.flagSeenSet = 1'b1;
          end
        end
        ADDR_CNT: next_st.rData[CNT_W-1:0] = st.refreshIntervalCounter;
        ADDR_COR: next_st.rData[CNT_W-1:0] = st.refreshCompareConstant;
        ADDR_SDRAM_CONTROL_REGISTER: next_st.rData[REFRESH_ENABLE_BIT] = st.refreshEnable;
        default: begin
          next_st.rData = '0;
          next_st.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (st.bus == SRTW_RRESP && s_axi_rready) begin
      next_st.bus = SRTW_IDLE;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign s_axi_awready = st.bus == SRTW_IDLE && !st.awTaken;
  assign s_axi_wready = st.bus == SRTW_IDLE && !st.wTaken;
  assign s_axi_bvalid = st.bus == SRTW_WRESP;
  assign s_axi_bresp = st.bResp;
  // reads wait while a response is outstanding and in the cycle a complete write pair fires
  assign s_axi_arready = st.bus == SRTW_IDLE && !wrFire;
  assign s_axi_rvalid = st.bus == SRTW_RRESP;
  assign s_axi_rdata = st.rData;
  // read response code tracks address decode
  assign s_axi_rresp = st.rResp;
  assign refreshReq = st.reqPending;
  assign refreshCycles = st.reqCycles;
  assign compareIrq = st.compareMatchFlag &&
    st.compareInterruptEnable;
  assign extBusStall = st.postResetWaitCounter != WAIT_TERMINAL;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  match_clears_a: assert property (@(posedge clock) disable iff (!arst_n)
    tick && match |=> st.refreshIntervalCounter == '0)
    else $error("counter not cleared on match");
  wrap_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    tick && !match && st.refreshIntervalCounter == 8'hFF && !wrFire
    |=> st.refreshIntervalCounter == '0)
    else $error("counter did not wrap");
  flag_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    tick && match |=> st.compareMatchFlag)
    else $error("match flag not set");
  req_raise_a: assert property (@(posedge clock) disable iff (!arst_n)
    tick && match && st.refreshEnable |=> refreshReq &&
    refreshCycles == $past(cyclesSel))
    else $error("refresh request missing");
  req_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    refreshReq && !refreshAck |=> refreshReq)
    else $error("refresh request dropped early");
  irq_follow_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(st.compareMatchFlag) |-> !compareIrq &&
    refreshReq == $past(refreshReq) || $past(refreshAck))
    else $error("flag clear disturbed request");
  irq_level_a: assert property (@(posedge clock) disable iff (!arst_n)
    compareIrq |-> st.compareMatchFlag)
    else $error("irq without flag");
  bad_key_a: assert property (@(posedge clock) disable iff (!arst_n)
    wrFire && st.awAddr == ADDR_COR && !keyOk
    |=> $stable(st.refreshCompareConstant))
    else $error("keyless write changed constant");
  stall_end_a: assert property (@(posedge clock) disable iff (!arst_n)
    !extBusStall |=> !extBusStall)
    else $error("wait counter restarted");
  halt_stop_a: assert property (@(posedge clock) disable iff (!arst_n)
    st.prescaleSelect == 3'h0 && !wrFire |=> $stable(
    st.refreshIntervalCounter))
    else $error("counter moved while halted");
  hi_zero_a: assert property (@(posedge clock) disable iff (!arst_n)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule

// [dv/srtw_seq_model.sv]
// srtw_seq_model: behavioural sdram refresh sequencer
// assumes: one clock domain, request held as a level until acked
`timescale 1ns/1ps
module srtw_seq_model (
  input wire logic clock, // bus clock
  input wire logic arst_n, // reset, active low
  input wire logic refreshReq, // pending refresh
  input wire logic [3:0] refreshCycles, // burst length
  input wire logic stall, // bench holds off service
  output logic refreshAck // refresh done, one-cycle pulse
);
  int busy;
  // ----------------------------------------------------------------
  // service: one refresh cycle per clock, then a single ack pulse
  // ----------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refreshAck <= 1'h0;
      busy <= 0;
    end else begin
      refreshAck <= 1'h0;
      // skip the ack cycle so one request is never acked twice
      if (refreshReq && !stall && !refreshAck) begin
        busy <= busy + 1;
        if (busy + 1 >= refreshCycles) begin
          refreshAck <= 1'h1;
          busy <= 0;
        end
      end
    end
  end
endmodule

// [dv/srtw_tb_top.sv]
// srtw_tb_top: self-checking bench for the refresh timer block
// assumes: AXI4-Lite master here, sequencer model on the refresh link
`timescale 1ns/1ps
module srtw_tb_top;
  import srtw_pkg::*;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0, refreshCycles;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, seqStall = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, refreshReq, refreshAck, compareIrq, extBusStall;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [15:0] key;
  logic [7:0] regs [4] = '{ADDR_CSR, ADDR_CNT, ADDR_COR, ADDR_SDRAM_CONTROL_REGISTER};
  int divTab [8] = '{0, 4, 16, 64, 256, 1024, 2048, 4096};
  int cycTab [5] = '{1, 2, 4, 6, 8};
  int mismatches = 0, totalChecks = 0, cyc = 0, t0, t1, n, i, c, v;

  srtw_refresh_timer u_dut (.clock, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .refreshReq, .refreshCycles, .refreshAck, .compareIrq, .extBusStall);
  srtw_seq_model u_seq (.clock, .arst_n, .refreshReq, .refreshCycles,
    .stall(seqStall), .refreshAck);

  always #25 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkPin(input logic got, input logic exp);
    chkReg({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bready and rready stay high, so only valids move here
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int k;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        br = s_axi_bresp;
        break;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic kw(input logic [7:0] a, input int v);
    axw(a, {WRITE_KEY, v[15:0]}, FULL_STROBE);
  endtask
  // counter is halted and zeroed first so the next match comes quickly
  task automatic mode(input int cks, input int rrc, input int ie);
    kw(ADDR_CSR, ie << 6);
    kw(ADDR_CNT, 0);
    kw(ADDR_CSR, (ie << 6) | (cks << 3) | rrc);
  endtask
  task automatic waitReq(input logic lv);
    int k;
    #1;
    for (k = 0; k < 20000 && refreshReq !== lv; k++) begin
      @(posedge clock);
      #1;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h1A620C5D));
    repeat (5) @(posedge clock);
    arst_n <= 1'h1;
    chkPin(extBusStall, 1'h1);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (extBusStall && n < 300);
    chkReg(n, 127);
    for (i = 0; i < 4; i++) begin
      axr(regs[i]);
      chkReg(rd, 32'h0);
    end
    axr(8'h10);
    chkReg(rd, 32'h0);
    chkReg(rr, RESP_SLVERR);
    axw(8'h10, {WRITE_KEY, 16'h007F}, FULL_STROBE);
    chkReg(br, RESP_SLVERR);
    for (i = 0; i < 3; i++) begin
      key = $urandom;
      if (key === WRITE_KEY) key = ~key;
      axw(regs[i], {key, 16'h0011}, FULL_STROBE);
      axw(regs[i], {WRITE_KEY, 16'h0022}, 4'h7);
      axr(regs[i]);
      chkReg(rd, 32'h0);
    end
    v = $urandom_range(255, 0);
    kw(ADDR_COR, v);
    chkReg(br, RESP_OKAY);
    axr(ADDR_COR);
    chkReg(rd, v);
    kw(ADDR_COR, 1);
    axw(ADDR_SDRAM_CONTROL_REGISTER, 32'h1, FULL_STROBE);
    for (i = 1; i < 8; i++) begin
      c = (i > 5) ? 4 : i - 1;
      mode(i, c, 0);
      waitReq(1'h1);
      chkReg(refreshCycles, cycTab[c]);
      t0 = cyc;
      waitReq(1'h0);
      waitReq(1'h1);
      chkReg(cyc - t0, 2 * divTab[i]);
      axr(ADDR_CSR);
      chkReg(rd, 32'h80 | (i << 3) | c);
    end
    kw(ADDR_CSR, 0);
    axr(ADDR_CNT);
    t1 = rd;
    repeat (300) @(posedge clock);
    axr(ADDR_CNT);
    chkReg(rd, t1);
    // sequencer held off: matches pile up onto one pending request
    seqStall <= 1'h1;
    mode(1, 0, 1);
    repeat (40) @(posedge clock);
    #1 chkPin(compareIrq, 1'h1);
    kw(ADDR_CSR, 16'h00C0);
    kw(ADDR_CSR, 16'h0040);
    #1 chkPin(compareIrq, 1'h1);
    axr(ADDR_CSR);
    chkReg(rd, 32'hC0);
    kw(ADDR_CSR, 16'h0040);
    #1 chkPin(compareIrq, 1'h0);
    chkPin(refreshReq, 1'h1);
    seqStall <= 1'h0;
    waitReq(1'h0);
    repeat (20) @(posedge clock);
    #1 chkPin(refreshReq, 1'h0);
    kw(ADDR_COR, 2);
    kw(ADDR_CNT, 16'h00FD);
    kw(ADDR_CSR, 16'h0008);
    t0 = cyc;
    waitReq(1'h1);
    chkPin((cyc - t0) >= 8 && (cyc - t0) <= 40, 1'h1);
    chkPin(extBusStall, 1'h0);
    wrap_up;
  end
  initial begin
    #4000000;
    mismatches++;
    wrap_up;
  end
endmodule
